// File: core/udcp_defines.vh
// constants shared by the command port of the usb device side
// assumes it is included by bare name from files under core/
//
// Behaviour
// - command-select bit high: low data byte is the command code.
// - commands without data phase act as soon as the code arrives.
// - command-select bit low: word moves to/from the latched target.
// - wider items go least significant byte or word first.
// - upper byte ignored in command phase and when undefined in data.
// - odd IN packet: upper byte of the last word is not sent.
// - packet length sits in the first two bytes of the buffer.
// - codes 20..2f write one configuration word per endpoint.
// - codes 30..3f read one configuration word per endpoint.
// - codes 01..0f send data words into the IN endpoint buffers.
// - transfer limit 1023 bytes isochronous, 64 bytes otherwise.
// - codes 10, 12..1f read data words from OUT endpoint buffers.
// - codes 40..4f stall, 80..8f unstall; no data phase.
// - codes 50..5f read one endpoint state word.
// - codes d0..df read one endpoint state copy word.
// - codes 61..6f validate an IN buffer; 60 is illegal.
// - codes 70, 72..7f clear an OUT buffer; 71 is illegal.
// - codes a0, a1 read one fault code word of a control endpoint.
// - code f4 acknowledges setup on both control endpoints at once.
// - reading the state copy changes no state or interrupt bit.
// - N bytes take (N + 1) DIV 2 data words.
`ifndef UDCP_DEFINES_VH
`define UDCP_DEFINES_VH

// command classes, upper nibble of the code
`define UDCP_CLS_BUFW 4'h0
`define UDCP_CLS_BUFR 4'h1
`define UDCP_CLS_CFGW 4'h2
`define UDCP_CLS_CFGR 4'h3
`define UDCP_CLS_STALL 4'h4
`define UDCP_CLS_STATE 4'h5
`define UDCP_CLS_VALID 4'h6
`define UDCP_CLS_CLEAR 4'h7
`define UDCP_CLS_UNSTALL 4'h8
`define UDCP_CLS_FAULT 4'ha
`define UDCP_CLS_COPY 4'hd
`define UDCP_CODE_SETUP 8'hf4

// endpoint numbers of the two control endpoints
`define UDCP_EP_CTRL_OUT 4'h0
`define UDCP_EP_CTRL_IN 4'h1

// configuration word: isochronous flag position, reset value
`define UDCP_CFG_ISO 4
`define UDCP_CFG_RESET 8'h00

// byte limits per transfer
`define UDCP_MAX_ISO 10'h3ff
`define UDCP_MAX_BULK 10'h040

// single-word read sources
`define UDCP_SRC_CFG 2'h0
`define UDCP_SRC_STATE 2'h1
`define UDCP_SRC_COPY 2'h2
`define UDCP_SRC_FAULT 2'h3

`endif

// File: core/udcp_pair_buffer.v
// two-entry buffer with valid/ready on both sides
// assumes one clock; all outputs come from flip-flops
`timescale 1ns/10ps
`default_nettype none
module udcp_pair_buffer #(
   parameter WIDTH = 22
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // filling side
   input wire inValid,
   output reg inReady,
   input wire [WIDTH-1:0] inData,
   // draining side
   output reg outValid,
   input wire outReady,
   output reg [WIDTH-1:0] outData
);

reg [WIDTH-1:0] spare;
reg spareFull;
wire push = inValid & inReady;
wire pop = outValid & outReady;

// slot 0 faces the drain, the spare slot catches a word during a stall
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      outValid <= 1'b0;
      spareFull <= 1'b0;
      inReady <= 1'b1;
      outData <= {WIDTH{1'b0}};
      spare <= {WIDTH{1'b0}};
   end else if (pop) begin
      if (spareFull) begin
         outData <= spare;
         spareFull <= 1'b0;
         inReady <= 1'b1;
      end else begin
         outData <= inData;
         outValid <= push;
      end
   end else if (push) begin
      if (!outValid) begin
         outData <= inData;
         outValid <= 1'b1;
      end else begin
         spare <= inData;
         spareFull <= 1'b1;
         inReady <= 1'b0; // full: host must wait before the next word
      end
   end
end

endmodule // udcp_pair_buffer
`default_nettype wire

// File: core/udcp_command_port.v
// command interpreter of the usb device side host port
// assumes a 16-bit host bus already synchronous to clk, one-cycle
// read and write strobes, and an endpoint engine that owns the fifos
// limitation: a new command code silently aborts an open data phase,
// so the host must finish a buffer transfer before the next code;
// the engine is expected to answer a word fetch within a few cycles;
// lengths above the endpoint limit are cut rather than refused
`timescale 1ns/10ps
`default_nettype none
`include "udcp_defines.vh"
module udcp_command_port #(
   parameter EP_COUNT = 16,
   parameter CFG_W = 8
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // host bus
   input wire commandSelect,
   input wire hostWrite,
   input wire hostRead,
   input wire [15:0] hostWrData,
   output reg [15:0] hostRdData,
   output reg hostRdValid,
   output wire hostWrReady,
   // endpoint control towards the engine
   output reg [3:0] epIndex,
   output reg stallSet,
   output reg stallClear,
   output reg bufValidate,
   output reg bufClear,
   output reg setupAck,
   output reg stateRead,
   output reg cfgWrite,
   output reg [CFG_W-1:0] cfgWrData,
   // engine state of the endpoint in epIndex
   input wire [7:0] epStateWord,
   input wire [7:0] epStateCopy,
   input wire [7:0] epFaultCode,
   // IN data towards the endpoint buffers
   output wire txValid,
   input wire txReady,
   output wire [15:0] txData,
   output wire txLast,
   output wire txOddLast,
   output wire [3:0] txEp,
   // OUT data from the endpoint buffers
   output reg rxPop,
   input wire rxValid,
   input wire [15:0] rxData
);

// phases, one-hot
// one-hot so the phase[1] and phase[3] tests each read a single flip-flop
localparam P_NONE = 5'b00001;
localparam P_CFGW = 5'b00010;
localparam P_REGR = 5'b00100;
localparam P_BUFW = 5'b01000;
localparam P_BUFR = 5'b10000;

// limits a length word to what the endpoint may carry
// a host that overstates the length cannot overrun the endpoint
function [9:0] clampLen;
   input [15:0] n;
   input iso;
   reg [9:0] lim;
   begin
      lim = iso ? `UDCP_MAX_ISO : `UDCP_MAX_BULK;
      clampLen = (n > {6'h00, lim}) ? lim : n[9:0];
   end
endfunction

// number of bus words a byte count takes
// odd counts round up; the last word then carries a single byte
function [9:0] wordsOf;
   input [9:0] n;
   reg [10:0] sum;
   begin
      sum = {1'b0, n} + 11'h001;
      wordsOf = sum[10:1];
   end
endfunction

// true unless the code names the given control endpoint; each
// control endpoint refuses one direction of buffer traffic
function notCtrl;
   input [3:0] ep;
   input [3:0] ctrl;
   begin
      notCtrl = (ep != ctrl);
   end
endfunction

// state
// firstWord marks the length word that opens every buffer transfer
// wordsLeft counts the payload words still owed in either direction
reg [4:0] phase;
reg [1:0] readSrc;
reg firstWord;
reg waitRx;
reg lenOdd;
reg [9:0] wordsLeft;
reg [CFG_W-1:0] cfgMem [0:EP_COUNT-1];

// host strobes split by phase of the access
// a read strobe that meets a write on the same edge is dropped
wire cmdStrobe = hostWrite & commandSelect;
wire dataWrite = hostWrite & ~commandSelect;
wire dataRead = hostRead & ~commandSelect;
wire [7:0] code = hostWrData[7:0]; // upper byte dropped
wire [3:0] codeCls = code[7:4];
wire [3:0] codeEp = code[3:0];
wire epIso = cfgMem[epIndex][`UDCP_CFG_ISO];

// IN word push into the buffer
// the length word of a transfer goes out to the engine as well
wire bufReady;
wire [9:0] wrLen = clampLen(hostWrData, epIso);
wire pushWord = dataWrite & phase[3] & bufReady;
wire pushLast = firstWord ? (wrLen == 10'h000) : (wordsLeft == 10'h001);
wire pushOdd = ~firstWord & pushLast & lenOdd;
wire [21:0] pushData = {epIndex, pushOdd, pushLast, hostWrData};
wire [21:0] headData;

// buffer outputs are flops already; they go out without extra logic
assign hostWrReady = bufReady;
assign txData = headData[15:0];
assign txLast = headData[16];
assign txOddLast = headData[17];
assign txEp = headData[21:18];

// two slots so a stall by the endpoint engine loses no word
// each slot packs endpoint, odd flag, last flag and the bus word
udcp_pair_buffer #(
   .WIDTH(22)
) wordBuffer (
   .clk(clk),
   .resetn(resetn),
   .inValid(pushWord),
   .inReady(bufReady),
   .inData(pushData),
   .outValid(txValid),
   .outReady(txReady),
   .outData(headData)
);

// single-word read source mux
// the source is fixed at command time; the word is taken at the read
reg [7:0] regWord;
always @* begin
   case (readSrc)
      `UDCP_SRC_CFG: regWord = cfgMem[epIndex];
      `UDCP_SRC_STATE: regWord = epStateWord;
      `UDCP_SRC_COPY: regWord = epStateCopy;
      default: regWord = epFaultCode;
   endcase
end

// configuration words, kept here so they read back unchanged
// the isochronous flag stored here also picks the length limit
integer i;
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      for (i = 0; i < EP_COUNT; i = i + 1) begin
         cfgMem[i] <= `UDCP_CFG_RESET;
      end
   end else if (dataWrite & phase[1]) begin
      cfgMem[epIndex] <= hostWrData[CFG_W-1:0];
   end
end

// command decode and data-phase handling
// every pulse towards the engine is a flop cleared on the next edge
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      phase <= P_NONE;
      readSrc <= `UDCP_SRC_CFG;
      firstWord <= 1'b0;
      waitRx <= 1'b0;
      lenOdd <= 1'b0;
      wordsLeft <= 10'h000;
      epIndex <= 4'h0;
      stallSet <= 1'b0;
      stallClear <= 1'b0;
      bufValidate <= 1'b0;
      bufClear <= 1'b0;
      setupAck <= 1'b0;
      stateRead <= 1'b0;
      cfgWrite <= 1'b0;
      cfgWrData <= `UDCP_CFG_RESET;
      rxPop <= 1'b0;
      hostRdData <= 16'h0000;
      hostRdValid <= 1'b0;
   end else begin
      // strobes towards the engine last one cycle
      stallSet <= 1'b0;
      stallClear <= 1'b0;
      bufValidate <= 1'b0;
      bufClear <= 1'b0;
      setupAck <= 1'b0;
      stateRead <= 1'b0;
      cfgWrite <= 1'b0;
      rxPop <= 1'b0;
      hostRdValid <= 1'b0;
      if (cmdStrobe) begin
         // a new code always aborts whatever data phase was open
         epIndex <= codeEp;
         firstWord <= 1'b1;
         waitRx <= 1'b0;
         phase <= P_NONE; // illegal codes end here
         case (codeCls)
            // IN buffers only; the control OUT code opens nothing
            `UDCP_CLS_BUFW: begin
               if (notCtrl(codeEp, `UDCP_EP_CTRL_OUT)) begin
                  phase <= P_BUFW;
               end
            end
            // OUT buffers only; the control IN code opens nothing
            `UDCP_CLS_BUFR: begin
               if (notCtrl(codeEp, `UDCP_EP_CTRL_IN)) begin
                  phase <= P_BUFR;
               end
            end
            // one-word register targets close after their single access
            `UDCP_CLS_CFGW: begin
               phase <= P_CFGW;
            end
            // config, state, copy and fault reads share the one-word path
            `UDCP_CLS_CFGR: begin
               phase <= P_REGR;
               readSrc <= `UDCP_SRC_CFG;
            end
            // the live state read lets the engine clear its bits afterwards
            `UDCP_CLS_STATE: begin
               phase <= P_REGR;
               readSrc <= `UDCP_SRC_STATE;
            end
            // the copy read is answered the same way but pulses nothing
            `UDCP_CLS_COPY: begin
               phase <= P_REGR;
               readSrc <= `UDCP_SRC_COPY;
            end
            // only the two control endpoints own a fault code word
            `UDCP_CLS_FAULT: begin
               if (codeEp[3:1] == 3'h0) begin
                  phase <= P_REGR;
                  readSrc <= `UDCP_SRC_FAULT;
               end
            end
            // no data phase: the engine acts on epIndex at the next edge
            `UDCP_CLS_STALL: begin
               stallSet <= 1'b1;
            end
            // the matching unstall uses the same endpoint field
            `UDCP_CLS_UNSTALL: begin
               stallClear <= 1'b1;
            end
            `UDCP_CLS_VALID: begin
               bufValidate <= notCtrl(codeEp, `UDCP_EP_CTRL_OUT);
            end
            `UDCP_CLS_CLEAR: begin
               bufClear <= notCtrl(codeEp, `UDCP_EP_CTRL_IN);
            end
            default: begin
               // setup acknowledge covers both control endpoints
               setupAck <= (code == `UDCP_CODE_SETUP);
            end
         endcase
      end else if (dataWrite) begin
         case (phase)
            P_CFGW: begin
               // the local copy updates on this same edge
               cfgWrite <= 1'b1;
               cfgWrData <= hostWrData[CFG_W-1:0];
               phase <= P_NONE;
            end
            P_BUFW: begin
               // a stalled buffer refuses the word; host polls ready
               if (bufReady) begin
                  firstWord <= 1'b0;
                  if (firstWord) begin
                     // length word leads the payload
                     lenOdd <= wrLen[0];
                     wordsLeft <= wordsOf(wrLen);
                  end else begin
                     wordsLeft <= wordsLeft - 10'h001;
                  end
                  // the last word closes the phase; later words are dropped
                  if (pushLast) begin
                     phase <= P_NONE;
                  end
               end
            end
            default: begin
               // no open write target: the word is dropped
               phase <= phase;
            end
         endcase
      end else if (dataRead && !waitRx) begin
         case (phase)
            P_REGR: begin
               hostRdData <= {8'h00, regWord};
               hostRdValid <= 1'b1;
               // only the live state read lets the engine clear bits;
               // the copy read leaves everything alone
               stateRead <= (readSrc == `UDCP_SRC_STATE);
               phase <= P_NONE;
            end
            P_BUFR: begin
               // one fetch at a time; a read during the fetch is ignored
               rxPop <= 1'b1; // fetch one word from the engine
               waitRx <= 1'b1;
            end
            default: begin
               // nothing selected: a defined zero answer
               hostRdData <= 16'h0000;
               hostRdValid <= 1'b1;
            end
         endcase
      end else if (waitRx && rxValid) begin
         // engine answered the fetch; pass it straight to the host
         waitRx <= 1'b0;
         hostRdData <= rxData;
         hostRdValid <= 1'b1;
         firstWord <= 1'b0;
         if (firstWord) begin
            // an overstated length is cut here as on the write side
            // length comes first, low byte first
            wordsLeft <= wordsOf(clampLen(rxData, epIso));
            if (clampLen(rxData, epIso) == 10'h000) begin
               phase <= P_NONE;
            end
         end else begin
            wordsLeft <= wordsLeft - 10'h001;
            if (wordsLeft == 10'h001) begin
               // odd tail byte is left for the host to drop
               phase <= P_NONE;
            end
         end
      end
   end
end

endmodule // udcp_command_port
`default_nettype wire

// File: bench/udcp_cp_props.sv
// checker of the command port: command pulses and read answers
// assumes it is bound onto udcp_command_port, one clock domain
`timescale 1ns/10ps
`default_nettype none
module udcp_cp_props (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // host bus
   input wire logic commandSelect,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [15:0] hostWrData,
   input wire logic [15:0] hostRdData,
   input wire logic hostRdValid,
   // endpoint control
   input wire logic [3:0] epIndex,
   input wire logic stallSet,
   input wire logic stallClear,
   input wire logic bufValidate,
   input wire logic bufClear,
   input wire logic setupAck,
   input wire logic stateRead,
   // OUT data
   input wire logic rxPop,
   input wire logic rxValid,
   input wire logic [15:0] rxData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // command write and its low byte; upper byte never looked at
   wire cw = hostWrite && commandSelect;
   wire [7:0] cc = hostWrData[7:0];
   wire dr = hostRead && !commandSelect;
   // class of the latest command code, to tell live from copy reads
   logic [3:0] lastCls;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lastCls <= 4'h0;
      end else if (cw) begin
         lastCls <= cc[7:4];
      end
   end

   a_stall_pulse: assert property (cw && cc[7:4] == 4'h4 |=>
      stallSet && epIndex == $past(cc[3:0])) else $error("stall missing");
   a_unstall_pulse: assert property (cw && cc[7:4] == 4'h8 |=>
      stallClear && !stallSet) else $error("unstall missing");
   a_validate_in: assert property (cw && cc[7:4] == 4'h6 |=>
      bufValidate == ($past(cc[3:0]) != 4'h0)) else $error("validate bad");
   a_clear_out: assert property (cw && cc[7:4] == 4'h7 |=>
      bufClear == ($past(cc[3:0]) != 4'h1)) else $error("clear bad");
   a_setup_both: assert property (cw && cc == 8'hf4 |=> setupAck)
      else $error("setup ack missing");
   a_no_stray: assert property (!cw |=> !(stallSet || stallClear ||
      bufValidate || bufClear || setupAck)) else $error("stray pulse");
   a_copy_quiet: assert property (stateRead |->
      $past(dr) && $past(lastCls) == 4'h5)
      else $error("state read without a live state read");
   a_pop_cause: assert property (rxPop |-> $past(dr))
      else $error("pop without bus read");
   a_rx_answer: assert property (rxPop ##1 rxValid |=>
      hostRdValid && hostRdData == $past(rxData))
      else $error("buffer word lost");

   c_stall: cover property (stallSet);
   c_pop: cover property (rxPop ##1 rxValid);
   c_state: cover property (stateRead);
endmodule // udcp_cp_props

bind udcp_command_port udcp_cp_props u_props (
   .clk(clk), .resetn(resetn), .commandSelect(commandSelect),
   .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
   .hostRdData(hostRdData), .hostRdValid(hostRdValid), .epIndex(epIndex),
   .stallSet(stallSet), .stallClear(stallClear), .bufValidate(bufValidate),
   .bufClear(bufClear), .setupAck(setupAck), .stateRead(stateRead),
   .rxPop(rxPop), .rxValid(rxValid), .rxData(rxData));
`default_nettype wire

// File: bench/udcp_engine_model.sv
// endpoint engine model: state words, IN sink, OUT word source
// assumes one buffer read per run; hold stalls the IN side
`timescale 1ns/10ps
`default_nettype none
module udcp_engine_model #(
   parameter logic [15:0] LEN = 16'h0003
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // selection and stall
   input wire logic [3:0] epIndex,
   input wire logic hold,
   // state of the selected endpoint
   output logic [7:0] epStateWord,
   output logic [7:0] epStateCopy,
   output logic [7:0] epFaultCode,
   // IN and OUT data
   output logic txReady,
   input wire logic rxPop,
   output logic rxValid,
   output logic [15:0] rxData
);
   logic [7:0] cnt;
   // words carry the endpoint number so a wrong index shows
   assign epStateWord = {4'h5, epIndex};
   assign epStateCopy = {4'hc, epIndex};
   assign epFaultCode = {4'ha, epIndex};
   assign txReady = !hold;
   // pop answered next cycle; idle data toggles so stale words show
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxValid <= 1'b0;
         rxData <= 16'h0000;
         cnt <= 8'h00;
      end else if (rxPop) begin
         rxValid <= 1'b1;
         rxData <= (cnt == 8'h00) ? LEN : {8'h11, cnt - 8'h01};
         cnt <= cnt + 8'h01;
      end else begin
         rxValid <= 1'b0;
         rxData <= ~rxData;
      end
   end
endmodule // udcp_engine_model
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench of the command port beside an engine model
// assumes design under core/, model and checker under bench/
`timescale 1ns/10ps
`default_nettype none
`define UDCP_CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
   miscompares++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module testbench;
   logic clk, resetn, commandSelect, hostWrite, hostRead, hold;
   logic [15:0] hostWrData;
   wire [15:0] hostRdData, txData, rxData;
   wire hostRdValid, hostWrReady, stallSet, stallClear, bufValidate;
   wire bufClear, setupAck, stateRead, cfgWrite, txValid, txReady, txLast;
   wire txOddLast, rxPop, rxValid;
   wire [3:0] epIndex, txEp;
   wire [7:0] cfgWrData, epStateWord, epStateCopy, epFaultCode;
   wire [4:0] pulses = {stallSet, stallClear, bufValidate, bufClear, setupAck};
   int miscompares, checked;
   logic [21:0] txq[$];

   udcp_command_port dut (.clk(clk), .resetn(resetn),
      .commandSelect(commandSelect), .hostWrite(hostWrite),
      .hostRead(hostRead), .hostWrData(hostWrData), .hostRdData(hostRdData),
      .hostRdValid(hostRdValid), .hostWrReady(hostWrReady), .epIndex(epIndex),
      .stallSet(stallSet), .stallClear(stallClear),
      .bufValidate(bufValidate),
      .bufClear(bufClear), .setupAck(setupAck), .stateRead(stateRead),
      .cfgWrite(cfgWrite), .cfgWrData(cfgWrData), .epStateWord(epStateWord),
      .epStateCopy(epStateCopy), .epFaultCode(epFaultCode), .txValid(txValid),
      .txReady(txReady), .txData(txData), .txLast(txLast),
      .txOddLast(txOddLast), .txEp(txEp), .rxPop(rxPop), .rxValid(rxValid),
      .rxData(rxData));
   udcp_engine_model model (.clk(clk), .resetn(resetn), .epIndex(epIndex),
      .hold(hold), .epStateWord(epStateWord), .epStateCopy(epStateCopy),
      .epFaultCode(epFaultCode), .txReady(txReady), .rxPop(rxPop),
      .rxValid(rxValid), .rxData(rxData));

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // words leaving the buffer, with endpoint and end flags
   always @(posedge clk) begin
      if (txValid === 1'b1 && txReady === 1'b1)
         txq.push_back({txEp, txLast, txOddLast, txData});
   end

   // one write access after an idle edge; writes with rdy set wait for room
   task automatic put(input logic cs, input logic [15:0] d, input bit rdy);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (rdy && hostWrReady !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      if (rdy) `UDCP_CHK("write ready", 1'b1, hostWrReady)
      commandSelect = cs;
      hostWrData = d; // whole aligned words only
      hostWrite = 1;
      @(posedge clk);
      #1 hostWrite = 0;
   endtask
   // one data read after an idle edge, answer waited for under a bound
   task automatic get(input logic [15:0] ex, input string nm);
      int n;
      n = 0;
      @(posedge clk);
      #1 commandSelect = 0;
      hostRead = 1;
      @(posedge clk);
      #1 hostRead = 0;
      while (hostRdValid !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      `UDCP_CHK("read valid", 1'b1, hostRdValid)
      `UDCP_CHK(nm, ex, hostRdData)
   endtask

   task automatic t_pulses;
      logic [12:0] tab [12];
      tab = '{{8'h40, 5'h10}, {8'h4f, 5'h10}, {8'h80, 5'h08}, {8'h8f, 5'h08},
         {8'h61, 5'h04}, {8'h6f, 5'h04}, {8'h60, 5'h00}, {8'h70, 5'h02},
         {8'h7f, 5'h02}, {8'h71, 5'h00}, {8'hf4, 5'h01}, {8'ha2, 5'h00}};
      // codes 00 and 11 are never sent
      // no OUT buffer is validated, no IN buffer cleared
      foreach (tab[i]) begin
         put(1'b1, {8'h5a, tab[i][12:5]}, 0); // junk upper byte
         `UDCP_CHK("pulses", tab[i][4:0], pulses)
      end
      put(1'b0, 16'h1234, 1); // dropped after an unknown code
      get(16'h0000, "after illegal");
   endtask
   task automatic t_cfg;
      put(1'b1, 16'hc522, 0);
      put(1'b0, 16'h3390, 1);
      `UDCP_CHK("cfgWrite", 1'b1, cfgWrite)
      `UDCP_CHK("cfgWrData", 8'h90, cfgWrData)
      put(1'b1, 16'h0032, 0);
      get(16'h0090, "cfg ep2");
      put(1'b1, 16'h0030, 0);
      get(16'h0000, "cfg ep0");
   endtask
   task automatic t_state;
      put(1'b1, 16'h0052, 0);
      get(16'h0052, "state");
      `UDCP_CHK("stateRead", 1'b1, stateRead)
      put(1'b1, 16'h00d3, 0);
      get(16'h00c3, "copy");
      `UDCP_CHK("copy stateRead", 1'b0, stateRead)
      put(1'b1, 16'h00a1, 0);
      get(16'h00a1, "fault");
   endtask
   // odd packet with the receiver stalled until the buffer refuses
   task automatic t_bufwrite;
      hold = 1;
      put(1'b1, 16'h0002, 0);
      put(1'b0, 16'h0003, 1);
      put(1'b0, 16'haabb, 1);
      `UDCP_CHK("ready when full", 1'b0, hostWrReady)
      put(1'b0, 16'h5555, 0); // refused, buffer full
      hold = 0;
      put(1'b0, 16'h00cc, 1);
      repeat (4) @(posedge clk);
      #1 `UDCP_CHK("words", 3, txq.size())
      `UDCP_CHK("length word", 22'h080003, txq[0])
      `UDCP_CHK("word 1", 22'h08aabb, txq[1])
      `UDCP_CHK("odd last", 22'h0b00cc, txq[2])
   endtask
   // 80 bytes on a bulk endpoint are cut to 64
   task automatic t_clamp;
      txq.delete();
      put(1'b1, 16'h0003, 0);
      put(1'b0, 16'h0050, 1);
      for (int k = 0; k < 32; k++)
         put(1'b0, k[15:0], 1);
      repeat (4) @(posedge clk);
      #1 `UDCP_CHK("clamp words", 33, txq.size())
      `UDCP_CHK("clamp last", 2'b10, txq[32][17:16])
      `UDCP_CHK("not last", 1'b0, txq[31][17])
   endtask
   task automatic t_bufread;
      put(1'b1, 16'h0012, 0);
      get(16'h0003, "rx length");
      get(16'h1100, "rx word 0");
      get(16'h1101, "rx word 1"); // upper byte is host's to drop
      get(16'h0000, "rx closed");
   endtask

   task automatic print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      resetn = 0;
      commandSelect = 0;
      hostWrite = 0;
      hostRead = 0;
      hostWrData = 16'h0000;
      hold = 0;
      miscompares = 0;
      checked = 0;
      repeat (10) @(posedge clk);
      #1 resetn = 1;
      t_pulses();
      t_cfg();
      t_state();
      t_bufwrite();
      t_clamp();
      t_bufread();
      print_verdict();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
